// ===== design/pio_ports.sv
// Three 8-bit quasi-bidirectional ports with pull-up control and 38 kHz modulation.
// Assumes the processor issues one-cycle special-register strobes on the system clock.
// Behaviour
// - Every pin has its own switchable weak pull-up, all enabled after reset.
// - With pull-up off the pin is open drain: drives low or floats.
// - Per-port pull-up control register holds one control bit per pin.
// - Each port bit is a latch loaded from the data bus on write strobe.
// - Latch-read request returns stored latch values, not pin levels.
// - Pin-read request returns the sampled level present on each pin.
// - Instruction picks latch or pin read path; read-modify-write uses latch.
// - With pull-up on, latch 0 drives pin low and latch 1 releases it.
// - An enabled on-chip peripheral takes control of its pin from the port.
// - Modulated pin is driven with latch XOR 38 kHz square wave.
// - Global modulation enable is bit 4 of the configuration register.
// - Eight pins each have a modulation select bit; all reset to zero.
// - Select bits 7..4 map to port1 bit6, port1 bit5, port2 bit3, port1 bit1.
// - Select bits 3..0 map to port0 bit2, port0 bit7, port0 bit5, port0 bit3.
// - A set pull-up control bit disables that pull-up; reset value clears it.
// - Every port data latch bit resets to one, pins start released high.
`timescale 1ns/1ns
`include "pio_ports_map.svh"

module pio_ports (
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic [7:0]        sfrAddr,
	input  wire logic [7:0]        sfrWrData,
	input  wire logic              sfrWrite,
	input  wire logic              sfrRead,
	input  wire logic              sfrReadLatch,
	output logic      [7:0]        sfrRdData,
	input  wire logic [23:0]       pinIn,
	output logic      [23:0]       pinOut,
	output logic      [23:0]       pinOe,
	output logic      [23:0]       pinPullupEn,
	input  wire logic [23:0]       periphEnable,
	input  wire logic [23:0]       periphOut,
	input  wire logic [23:0]       periphOe,
	output logic                   modWave
);

	pio_pkg::pio_byte_t   latch0_q;
	pio_pkg::pio_byte_t   latch1_q;
	pio_pkg::pio_byte_t   latch2_q;
	pio_pkg::pio_byte_t   puDis0_q;
	pio_pkg::pio_byte_t   puDis1_q;
	pio_pkg::pio_byte_t   puDis2_q;
	pio_pkg::pio_byte_t   modSel_q;
	logic                 modGlobalEn_q;
	pio_pkg::pio_pins_t   syncA_q;
	pio_pkg::pio_pins_t   syncB_q;
	pio_pkg::pio_pins_t   syncC_q;
	pio_pkg::pio_pins_t   pinSampled_q;
	pio_pkg::pio_div_t    divCount_q;
	logic                 sqWave_q;
	pio_pkg::pio_pins_t   latchAll;
	pio_pkg::pio_pins_t   modMask;
	pio_pkg::pio_pins_t   driveLevel;
	pio_pkg::pio_pins_t   oe_d;
	pio_pkg::pio_pins_t   out_d;
	pio_pkg::pio_byte_t   rd_d;
	pio_pkg::pio_pins_t   oe_q;
	pio_pkg::pio_pins_t   out_q;
	pio_pkg::pio_byte_t   rd_q;

	logic wrPort0;
	logic wrPort1;
	logic wrPort2;

	assign wrPort0 = sfrWrite && (sfrAddr == `PIO_ADDR_PORT0);
	assign wrPort1 = sfrWrite && (sfrAddr == `PIO_ADDR_PORT1);
	assign wrPort2 = sfrWrite && (sfrAddr == `PIO_ADDR_PORT2);

	// Port data latches
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			latch0_q <= `PIO_LATCH_RST;
			latch1_q <= `PIO_LATCH_RST;
			latch2_q <= `PIO_LATCH_RST;
		end else begin
			if (wrPort0) begin
				latch0_q <= sfrWrData;
			end
			if (wrPort1) begin
				latch1_q <= sfrWrData;
			end
			if (wrPort2) begin
				latch2_q <= sfrWrData;
			end
		end
	end

	// Pull-up disable registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			puDis0_q <= `PIO_PUDIS_RST;
			puDis1_q <= `PIO_PUDIS_RST;
			puDis2_q <= `PIO_PUDIS_RST;
		end else if (sfrWrite) begin
			if (sfrAddr == `PIO_ADDR_PUDIS0) begin
				puDis0_q <= sfrWrData;
			end
			if (sfrAddr == `PIO_ADDR_PUDIS1) begin
				puDis1_q <= sfrWrData;
			end
			if (sfrAddr == `PIO_ADDR_PUDIS2) begin
				puDis2_q <= sfrWrData;
			end
		end
	end

	assign pinPullupEn = ~{puDis2_q, puDis1_q, puDis0_q};

	// Modulation select and global enable
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			modSel_q      <= `PIO_MODSEL_RST;
			modGlobalEn_q <= 1'b0;
		end else if (sfrWrite) begin
			if (sfrAddr == `PIO_ADDR_MODSEL) begin
				modSel_q <= sfrWrData;
			end
			if (sfrAddr == `PIO_ADDR_CONFIG) begin
				modGlobalEn_q <= sfrWrData[`PIO_MODEN_BIT];
			end
		end
	end

	// Select bit to pin mapping
	always_comb begin
		modMask = `PIO_ZERO_PINS;
		modMask[`PIO_MODPIN_SEL7] = modSel_q[7];
		modMask[`PIO_MODPIN_SEL6] = modSel_q[6];
		modMask[`PIO_MODPIN_SEL5] = modSel_q[5];
		modMask[`PIO_MODPIN_SEL4] = modSel_q[4];
		modMask[`PIO_MODPIN_SEL3] = modSel_q[3];
		modMask[`PIO_MODPIN_SEL2] = modSel_q[2];
		modMask[`PIO_MODPIN_SEL1] = modSel_q[1];
		modMask[`PIO_MODPIN_SEL0] = modSel_q[0];
		if (!modGlobalEn_q) begin
			modMask = `PIO_ZERO_PINS;
		end
	end

	// Free-running 38 kHz divider
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			divCount_q <= '0;
			sqWave_q   <= 1'b0;
		end else if (divCount_q == `PIO_DIV_W'(`PIO_HALF_CYCLES - 1)) begin
			divCount_q <= '0;
			sqWave_q   <= ~sqWave_q;
		end else begin
			divCount_q <= divCount_q + `PIO_DIV_W'(1);
		end
	end

	assign modWave = sqWave_q;

	// Pin drive: port drives low only, pull-up or float releases high; an enabled peripheral drives its own level
	always_comb begin
		latchAll   = {latch2_q, latch1_q, latch0_q};
		driveLevel = latchAll ^ (modMask & {`PIO_NPINS{sqWave_q}});
		oe_d       = ~driveLevel;
		out_d      = `PIO_ZERO_PINS;
		oe_d       = (oe_d & ~periphEnable) | (periphOe & periphEnable);
		out_d      = (out_d & ~periphEnable) | (periphOut & periphEnable);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			oe_q  <= `PIO_ZERO_PINS;
			out_q <= `PIO_ZERO_PINS;
		end else begin
			oe_q  <= oe_d;
			out_q <= out_d;
		end
	end

	assign pinOe  = oe_q;
	assign pinOut = out_q;

	// Pin sampling, change taken when second and third stage agree
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			syncA_q      <= `PIO_ONES_PINS;
			syncB_q      <= `PIO_ONES_PINS;
			syncC_q      <= `PIO_ONES_PINS;
			pinSampled_q <= `PIO_ONES_PINS;
		end else begin
			syncA_q      <= pinIn;
			syncB_q      <= syncA_q;
			syncC_q      <= syncB_q;
			pinSampled_q <= (pinSampled_q & ~(syncB_q ^~ syncC_q)) | (syncC_q & (syncB_q ^~ syncC_q));
		end
	end

	// Read path
	always_comb begin
		rd_d = `PIO_ZERO_BYTE;
		case (sfrAddr)
			`PIO_ADDR_PORT0: begin
				rd_d = sfrReadLatch ? latch0_q : pinSampled_q[`PIO_P0_HI:`PIO_P0_LO];
			end
			`PIO_ADDR_PORT1: begin
				rd_d = sfrReadLatch ? latch1_q : pinSampled_q[`PIO_P1_HI:`PIO_P1_LO];
			end
			`PIO_ADDR_PORT2: begin
				rd_d = sfrReadLatch ? latch2_q : pinSampled_q[`PIO_P2_HI:`PIO_P2_LO];
			end
			`PIO_ADDR_MODSEL: begin
				rd_d = modSel_q;
			end
			`PIO_ADDR_CONFIG: begin
				rd_d[`PIO_MODEN_BIT] = modGlobalEn_q;
			end
			`PIO_ADDR_PUDIS0: begin
				rd_d = puDis0_q;
			end
			`PIO_ADDR_PUDIS1: begin
				rd_d = puDis1_q;
			end
			`PIO_ADDR_PUDIS2: begin
				rd_d = puDis2_q;
			end
			default: begin
				rd_d = `PIO_ZERO_BYTE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= `PIO_ZERO_BYTE;
		end else if (sfrRead) begin
			rd_q <= rd_d;
		end
	end

	assign sfrRdData = rd_q;

	chk_latch_write: assert property (@(posedge clock) disable iff (!reset_n)
		wrPort1 |=> latch1_q == $past(sfrWrData)) else $error("port latch did not capture write data");

	chk_latch_read: assert property (@(posedge clock) disable iff (!reset_n)
		sfrRead && sfrReadLatch && sfrAddr == `PIO_ADDR_PORT0 |=> sfrRdData == $past(latch0_q))
		else $error("latch read returned wrong value");

	chk_pin_read: assert property (@(posedge clock) disable iff (!reset_n)
		sfrRead && !sfrReadLatch && sfrAddr == `PIO_ADDR_PORT1
		|=> sfrRdData == $past(pinSampled_q[`PIO_P1_HI:`PIO_P1_LO]))
		else $error("pin read returned wrong value");

	chk_pullup_write: assert property (@(posedge clock) disable iff (!reset_n)
		sfrWrite && sfrAddr == `PIO_ADDR_PUDIS0 |=> pinPullupEn[`PIO_P0_HI:`PIO_P0_LO] == ~$past(sfrWrData))
		else $error("pull-up enable does not follow disable register");

	chk_drive_low: assert property (@(posedge clock) disable iff (!reset_n)
		wrPort0 && !sfrWrData[0] && !periphEnable[0] ##1 !periphEnable[0] |=> pinOe[0] && !pinOut[0])
		else $error("latch zero did not drive pin low");

	chk_release_high: assert property (@(posedge clock) disable iff (!reset_n)
		latch0_q[1] && !periphEnable[1] |=> !pinOe[1]) else $error("released pin still driven");

	chk_periph_owns: assert property (@(posedge clock) disable iff (!reset_n)
		periphEnable[4] |=> pinOe[4] == $past(periphOe[4]) && pinOut[4] == $past(periphOut[4]))
		else $error("peripheral does not own its pin");

	chk_mod_xor: assert property (@(posedge clock) disable iff (!reset_n)
		modGlobalEn_q && modSel_q[7] && !latchAll[`PIO_MODPIN_SEL7] && !periphEnable[`PIO_MODPIN_SEL7]
		|=> pinOe[`PIO_MODPIN_SEL7] == !$past(sqWave_q))
		else $error("modulated pin does not follow square wave");

	chk_mod_gated: assert property (@(posedge clock) disable iff (!reset_n)
		!modGlobalEn_q && !periphEnable[3] |=> pinOe[3] == !$past(latch0_q[3]))
		else $error("pin modulated while global enable is off");

	chk_wave_period: assert property (@(posedge clock) disable iff (!reset_n)
		$changed(sqWave_q) |-> $past(divCount_q) == `PIO_DIV_W'(`PIO_HALF_CYCLES - 1))
		else $error("square wave toggled off its half period");

	chk_modsel_map: assert property (@(posedge clock) disable iff (!reset_n)
		modGlobalEn_q |-> modMask[`PIO_MODPIN_SEL5] == modSel_q[5] && modMask[`PIO_MODPIN_SEL7] == modSel_q[7])
		else $error("modulation select mapped to wrong pin");

	chk_latch_hold: assert property (@(posedge clock) disable iff (!reset_n)
		!wrPort0 && !wrPort2 |=> $stable(latch0_q) && $stable(latch2_q))
		else $error("port latch changed without a write");

	chk_port2_latch_write: assert property (@(posedge clock) disable iff (!reset_n)
		wrPort2 |=> latch2_q == $past(sfrWrData))
		else $error("port two latch did not capture write data");

	chk_port1_latch_read: assert property (@(posedge clock) disable iff (!reset_n)
		sfrRead && sfrReadLatch && sfrAddr == `PIO_ADDR_PORT1 |=> sfrRdData == $past(latch1_q))
		else $error("port one latch read returned wrong value");

	chk_port0_pin_read: assert property (@(posedge clock) disable iff (!reset_n)
		sfrRead && !sfrReadLatch && sfrAddr == `PIO_ADDR_PORT0
		|=> sfrRdData == $past(pinSampled_q[`PIO_P0_HI:`PIO_P0_LO]))
		else $error("port zero pin read returned wrong value");

	chk_sample_take: assert property (@(posedge clock) disable iff (!reset_n)
		syncB_q == syncC_q |=> pinSampled_q == $past(syncC_q))
		else $error("agreed pin level was not taken");

	chk_sample_hold: assert property (@(posedge clock) disable iff (!reset_n)
		syncB_q[`PIO_P1_LO] != syncC_q[`PIO_P1_LO] |=> $stable(pinSampled_q[`PIO_P1_LO]))
		else $error("pin sample moved before the stages agreed");

	chk_pullup_port1: assert property (@(posedge clock) disable iff (!reset_n)
		sfrWrite && sfrAddr == `PIO_ADDR_PUDIS1 |=> pinPullupEn[`PIO_P1_HI:`PIO_P1_LO] == ~$past(sfrWrData))
		else $error("port one pull-up does not follow its register");

	chk_pullup_port2: assert property (@(posedge clock) disable iff (!reset_n)
		sfrWrite && sfrAddr == `PIO_ADDR_PUDIS2 |=> pinPullupEn[`PIO_P2_HI:`PIO_P2_LO] == ~$past(sfrWrData))
		else $error("port two pull-up does not follow its register");

	chk_pullup_hold: assert property (@(posedge clock) disable iff (!reset_n)
		!sfrWrite |=> $stable(pinPullupEn))
		else $error("pull-up changed without a write");

	chk_global_write: assert property (@(posedge clock) disable iff (!reset_n)
		sfrWrite && sfrAddr == `PIO_ADDR_CONFIG |=> modGlobalEn_q == $past(sfrWrData[`PIO_MODEN_BIT]))
		else $error("global modulation enable not taken from its bit");

	chk_config_read: assert property (@(posedge clock) disable iff (!reset_n)
		sfrRead && sfrAddr == `PIO_ADDR_CONFIG
		|=> sfrRdData == (pio_pkg::pio_byte_t'($past(modGlobalEn_q)) << `PIO_MODEN_BIT))
		else $error("configuration read shows more than the enable bit");

	chk_modsel_write: assert property (@(posedge clock) disable iff (!reset_n)
		sfrWrite && sfrAddr == `PIO_ADDR_MODSEL |=> modSel_q == $past(sfrWrData))
		else $error("modulation select not taken from write data");

	chk_sel5_drive: assert property (@(posedge clock) disable iff (!reset_n)
		modGlobalEn_q && modSel_q[5] && latchAll[`PIO_MODPIN_SEL5] && !periphEnable[`PIO_MODPIN_SEL5]
		|=> pinOe[`PIO_MODPIN_SEL5] == $past(sqWave_q))
		else $error("select bit five does not modulate its pin");

	chk_sel3_drive: assert property (@(posedge clock) disable iff (!reset_n)
		modGlobalEn_q && modSel_q[3] && latchAll[`PIO_MODPIN_SEL3] && !periphEnable[`PIO_MODPIN_SEL3]
		|=> pinOe[`PIO_MODPIN_SEL3] == $past(sqWave_q))
		else $error("select bit three does not modulate its pin");

	chk_unselected_pins: assert property (@(posedge clock) disable iff (!reset_n)
		modSel_q == `PIO_ZERO_BYTE && periphEnable == `PIO_ZERO_PINS |=> pinOe == ~$past(latchAll))
		else $error("pin drive differs from latch without modulation");

	chk_div_wrap: assert property (@(posedge clock) disable iff (!reset_n)
		divCount_q == `PIO_DIV_W'(`PIO_HALF_CYCLES - 1) |=> divCount_q == `PIO_DIV_W'(0))
		else $error("divider did not wrap at its half period");

	chk_div_count: assert property (@(posedge clock) disable iff (!reset_n)
		divCount_q != `PIO_DIV_W'(`PIO_HALF_CYCLES - 1)
		|=> divCount_q == $past(divCount_q) + `PIO_DIV_W'(1) && $stable(sqWave_q))
		else $error("divider skipped a count or wave toggled early");

	chk_gpio_low_only: assert property (@(posedge clock) disable iff (!reset_n)
		periphEnable == `PIO_ZERO_PINS |=> pinOut == `PIO_ZERO_PINS)
		else $error("general purpose pin driven high");

endmodule

// ===== design/pio_ports_map.svh
// Address map, field positions, reset values and timing counts of the parallel port block.
// Included by name from the package and the port module.
`ifndef PIO_PORTS_MAP_SVH
`define PIO_PORTS_MAP_SVH

`define PIO_ADDR_PORT0      8'h80
`define PIO_ADDR_PORT1      8'h90
`define PIO_ADDR_MODSEL     8'h9f
`define PIO_ADDR_PORT2      8'ha0
`define PIO_ADDR_CONFIG     8'haf
`define PIO_ADDR_PUDIS0     8'hb2
`define PIO_ADDR_PUDIS1     8'hb3
`define PIO_ADDR_PUDIS2     8'hb4

`define PIO_MODEN_BIT       4

`define PIO_LATCH_RST       8'hff
`define PIO_PUDIS_RST       8'h00
`define PIO_MODSEL_RST      8'h00
`define PIO_ZERO_BYTE       8'h00
`define PIO_ZERO_PINS       24'h000000
`define PIO_ONES_PINS       24'hffffff

`define PIO_NPINS           24
`define PIO_P0_LO           0
`define PIO_P0_HI           7
`define PIO_P1_LO           8
`define PIO_P1_HI           15
`define PIO_P2_LO           16
`define PIO_P2_HI           23

// Pin index (port * 8 + bit) for each modulation select bit
`define PIO_MODPIN_SEL7     14
`define PIO_MODPIN_SEL6     13
`define PIO_MODPIN_SEL5     19
`define PIO_MODPIN_SEL4     9
`define PIO_MODPIN_SEL3     2
`define PIO_MODPIN_SEL2     7
`define PIO_MODPIN_SEL1     5
`define PIO_MODPIN_SEL0     3

`define PIO_CLK_HZ          125000000
`define PIO_MOD_HZ          38000
`define PIO_HALF_CYCLES     (`PIO_CLK_HZ / (2 * `PIO_MOD_HZ))
`define PIO_DIV_W           11

`endif

// ===== design/pio_pkg.sv
// Types shared by the parallel port block.
// Assumes pio_ports_map.svh is on the include path.
`include "pio_ports_map.svh"

package pio_pkg;
	typedef logic [7:0]              pio_byte_t;
	typedef logic [`PIO_NPINS-1:0]   pio_pins_t;
	typedef logic [`PIO_DIV_W-1:0]   pio_div_t;
endpackage

// ===== verification/pio_pin_world.sv
// External devices and wire resolution on the 24 port pins.
// Assumes the port block's drive, enable and pull-up outputs.
`timescale 1ns/1ns

module pio_pin_world (
	input  wire logic        clock,
	input  wire logic [23:0] pinOut,
	input  wire logic [23:0] pinOe,
	input  wire logic [23:0] pinPullupEn,
	input  wire logic [23:0] extEn,
	input  wire logic [23:0] extVal,
	output logic      [23:0] pinLevel
);
	logic [23:0] floatQ = 24'h000000;

	// Undriven pins without pull-up wander every cycle
	always @(posedge clock) begin
		floatQ <= ~floatQ;
	end

	// Device drive wins, then external drive, then pull-up or float
	assign pinLevel = (pinOe & pinOut) | (~pinOe & extEn & extVal)
		| (~pinOe & ~extEn & (pinPullupEn | floatQ));
endmodule

// ===== verification/pio_ports_tb_top.sv
// Self-checking bench for the parallel port block.
// Assumes the pin world model and the block's address map header.
`timescale 1ns/1ns
`include "pio_ports_map.svh"

module pio_ports_tb_top;
	logic          clock = 1'b0;
	logic          reset_n = 1'b0;
	logic [7:0]    sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, d;
	logic          sfrWrite = 1'b0, sfrRead = 1'b0, sfrReadLatch = 1'b0, modWave;
	logic [23:0]   pinIn, pinOut, pinOe, pinPullupEn;
	logic [23:0]   periphEnable = 24'h000000, periphOut = 24'h000000, periphOe = 24'h000000;
	logic [23:0]   extEn = 24'h000000, extVal = 24'h000000;
	int            bad_count = 0, num_checks = 0, n;
	int            pinOf[8] = '{3, 5, 7, 2, 9, 19, 13, 14};
	localparam int HALF = 125000000 / (2 * 38000);

	pio_ports u_pio_ports (.clock(clock), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
		.sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrReadLatch(sfrReadLatch), .sfrRdData(sfrRdData),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPullupEn(pinPullupEn),
		.periphEnable(periphEnable), .periphOut(periphOut), .periphOe(periphOe), .modWave(modWave));
	pio_pin_world u_pio_pin_world (.clock(clock), .pinOut(pinOut), .pinOe(pinOe), .pinPullupEn(pinPullupEn),
		.extEn(extEn), .extVal(extVal), .pinLevel(pinIn));

	always #4 clock = ~clock;

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		sfrAddr <= a;
		sfrWrData <= v;
		sfrWrite <= 1'b1;
		@(posedge clock);
		sfrWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic l);
		@(posedge clock);
		sfrAddr <= a;
		sfrReadLatch <= l;
		sfrRead <= 1'b1;
		@(posedge clock);
		sfrRead <= 1'b0;
		settle(1);
		d = sfrRdData;
	endtask

	task automatic wait_wave(input logic v);
		#1;
		n = 0;
		while (modWave !== v && n < 4000) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask

	task automatic t_reset();
		wr(`PIO_ADDR_PORT0, 8'h00);
		wr(`PIO_ADDR_PORT2, 8'h00);
		wr(`PIO_ADDR_PUDIS0, 8'h5a);
		settle(2);
		chk(pinPullupEn, 24'hffffa5);
		chk(pinOe, 24'hff00ff);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd(`PIO_ADDR_PORT0, 1'b1); chk(24'(d), 24'h0000ff);
		rd(`PIO_ADDR_PORT0, 1'b0); chk(24'(d), 24'h0000ff);
		rd(`PIO_ADDR_PUDIS0, 1'b0); chk(24'(d), 24'h000000);
		rd(`PIO_ADDR_PORT2, 1'b1); chk(24'(d), 24'h0000ff);
		rd(`PIO_ADDR_PUDIS1, 1'b0); chk(24'(d), 24'h000000);
		rd(`PIO_ADDR_MODSEL, 1'b0); chk(24'(d), 24'h000000);
		rd(8'h81, 1'b0); chk(24'(d), 24'h000000);
		chk(pinPullupEn, 24'hffffff);
		chk(pinOe, 24'h000000);
		$display("reset test done");
	endtask

	task automatic t_gpio();
		wr(`PIO_ADDR_PORT1, 8'h5a);
		settle(6);
		chk(pinOe, 24'h00a500);
		rd(`PIO_ADDR_PORT1, 1'b1); chk(24'(d), 24'h00005a);
		rd(`PIO_ADDR_PORT1, 1'b0); chk(24'(d), 24'h00005a);
		wr(`PIO_ADDR_PORT1, 8'hff);
		extEn <= 24'h000100;
		settle(6);
		rd(`PIO_ADDR_PORT1, 1'b1); chk(24'(d), 24'h0000ff);
		rd(`PIO_ADDR_PORT1, 1'b0); chk(24'(d), 24'h0000fe);
		@(posedge clock);
		extEn <= 24'h000000;
		$display("gpio test done");
	endtask

	task automatic t_pullup();
		wr(`PIO_ADDR_PUDIS1, 8'h0f);
		wr(`PIO_ADDR_PUDIS2, 8'h80);
		wr(`PIO_ADDR_PORT1, 8'h0f);
		extEn <= 24'h000300;
		extVal <= 24'h000100;
		settle(6);
		chk(pinPullupEn, 24'h7ff0ff);
		chk(pinOe & 24'h00ff00, 24'h00f000);
		chk(pinOut & 24'h00ff00, 24'h000000);
		rd(`PIO_ADDR_PORT1, 1'b0); chk(24'(d & 8'hf3), 24'h000001);
		rd(`PIO_ADDR_PUDIS1, 1'b0); chk(24'(d), 24'h00000f);
		@(posedge clock);
		extEn <= 24'h000000;
		wr(`PIO_ADDR_PORT1, 8'hff);
		wr(`PIO_ADDR_PUDIS1, 8'h00);
		wr(`PIO_ADDR_PUDIS2, 8'h00);
		$display("pull-up test done");
	endtask

	task automatic t_periph();
		@(posedge clock);
		periphEnable <= 24'h000011;
		periphOe <= 24'h000011;
		periphOut <= 24'h000011;
		settle(3);
		chk(pinOe & 24'h000011, 24'h000011);
		chk(pinOut & 24'h000011, 24'h000011);
		@(posedge clock);
		periphOut <= 24'h000000;
		settle(3);
		chk(pinOe & 24'h000011, 24'h000011);
		chk(pinOut & 24'h000011, 24'h000000);
		@(posedge clock);
		periphEnable <= 24'h000000;
		settle(3);
		chk(pinOe, 24'h000000);
		chk(pinOut, 24'h000000);
		$display("peripheral test done");
	endtask

	task automatic t_mod();
		wr(`PIO_ADDR_MODSEL, 8'hff);
		settle(3);
		chk(pinOe, 24'h000000);
		wr(`PIO_ADDR_CONFIG, 8'hff);
		rd(`PIO_ADDR_CONFIG, 1'b0); chk(24'(d), 24'h000010);
		wait_wave(1'b0);
		wait_wave(1'b1);
		wait_wave(1'b0); chk(24'(n), 24'(HALF));
		wait_wave(1'b1); chk(24'(n), 24'(HALF));
		for (int i = 0; i < 8; i++) begin
			wr(`PIO_ADDR_MODSEL, 8'h01 << i);
			wait_wave(1'b0);
			wait_wave(1'b1);
			settle(3);
			chk(pinOe, 24'h000001 << pinOf[i]);
		end
		wr(`PIO_ADDR_PORT1, 8'hbf);
		wait_wave(1'b1);
		wait_wave(1'b0);
		settle(3);
		chk(pinOe, 24'h004000);
		wait_wave(1'b1);
		settle(3);
		chk(pinOe, 24'h000000);
		wr(`PIO_ADDR_CONFIG, 8'h00);
		settle(3);
		chk(pinOe, 24'h004000);
		wr(`PIO_ADDR_PORT1, 8'hff);
		$display("modulation test done");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		t_reset();
		t_gpio();
		t_pullup();
		t_periph();
		t_mod();
		close_out();
	end

	initial begin
		#480000;
		bad_count++;
		close_out();
	end
endmodule
